// file: shared/src_consts.svh
// Register offsets, field positions and reset values for src control
`ifndef SRC_CONSTS_SVH
`define SRC_CONSTS_SVH
`define SRC_ADDR_ENABLE     16'h0EE0
`define SRC_ADDR_STATUS     16'h0EE1
`define SRC_ADDR_SYS_RATE   16'h0EE2
`define SRC_ADDR_ALT_RATE   16'h0EE3
`define SRC_ADDR_I1_HIGH    16'h0EF0
`define SRC_ADDR_I1_LOW     16'h0EF1
`define SRC_ADDR_I1_PATHS   16'h0EF2
`define SRC_ADDR_I2_HIGH    16'h0EF3
`define SRC_ADDR_I2_LOW     16'h0EF4
`define SRC_ADDR_I2_PATHS   16'h0EF5
`define SRC_RATE_MSB        14
`define SRC_RATE_LSB        11
`define SRC_RATE_SYS_RST    4'h0
`define SRC_RATE_ALT_RST    4'h8
`define SRC_RATE_SYS1       4'h0
`define SRC_RATE_SYS2       4'h1
`define SRC_RATE_SYS3       4'h2
`define SRC_RATE_ALT1       4'h8
`define SRC_RATE_ALT2       4'h9
`define SRC_A1R_BIT         0
`define SRC_A1L_BIT         1
`define SRC_A2R_BIT         2
`define SRC_A2L_BIT         3
`define SRC_I1_INT_MSB      15
`define SRC_I1_INT_LSB      12
`define SRC_I1_DEC_MSB      9
`define SRC_I1_DEC_LSB      6
`define SRC_I2_INT_MSB      15
`define SRC_I2_INT_LSB      14
`define SRC_I2_DEC_MSB      9
`define SRC_I2_DEC_LSB      8
`define SRC_NOTCH_BIT       0
`define SRC_ZERO16          16'h0000
`endif

// file: shared/src_pkg.sv
// Types shared by the sample rate converter control block
package src_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } src_req_s;

  typedef struct packed {
    logic [3:0] async_en;
    logic [3:0] i1_interp;
    logic [3:0] i1_decim;
    logic       i1_notch;
    logic [1:0] i2_interp;
    logic [1:0] i2_decim;
    logic       i2_notch;
  } src_paths_s;

  typedef enum logic [1:0] {
    SRC_CHK_IDLE  = 2'b00,
    SRC_CHK_EVAL  = 2'b01,
    SRC_CHK_ERROR = 2'b10
  } src_chk_e;
endpackage

// file: hdl/src_ctrl.sv
// Sample rate converter control, status and clock sufficiency gate
// ***************************************************************
// Summary of operation
// R1 - Async conv1 right enable at bit 0
// R2 - Other async enables at bits 3,2,1
// R3 - Read-only async path status mirrors
// R4 - System rate select bits 14:11, reset 0000
// R5 - Alternate rate select bits 14:11, reset 1000
// R6 - Software uses only listed async rates
// R7 - Software clears sources before async rate change
// R8 - Async lock status reported as event
// R9 - Two iso converters, four and two paths
// R10 - Software keeps iso rates in one domain
// R11 - Software picks rate groups per domain
// R12 - Software keeps integer ratios within range
// R13 - Software puts higher rate in high select
// R14 - Iso rate selects bits 14:11, reset 0000
// R15 - Software clears sources, waits before rate
// R16 - Decim sources for high, interp for low
// R17 - Iso1 interp enables bits 15 to 12
// R18 - Iso1 decim enables bits 9 to 6
// R19 - Iso2 interp 15,14, decim 9,8, notch 0
// R20 - Notch enable bit 0, reset 0
// R21 - Refuse enables without enough clock cycles
// R22 - Refusal raises underclocked error output
// R23 - Software routes sources at matching rate
// R24 - Status set only after accepted enable
// ***************************************************************
`timescale 1ns/10ps
`include "src_consts.svh"

module src_ctrl (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Register port
  input  wire src_pkg::src_req_s   req,
  output logic [15:0]              rdata,
  // Clock sufficiency and lock inputs from the core
  input  wire logic [15:0]         cycle_budget,
  input  wire logic [3:0]          async_lock_in,
  // Path controls to the converters
  output src_pkg::src_paths_s      paths,
  output logic [3:0]               sys_rate_sel,
  output logic [3:0]               alt_rate_sel,
  output logic [3:0]               i1_high_sel,
  output logic [3:0]               i1_low_sel,
  output logic [3:0]               i2_high_sel,
  output logic [3:0]               i2_low_sel,
  // Events
  output logic [3:0]               async_lock,
  output logic                     underclock_err
);
  import src_pkg::*;

  // ***************************************************************
  // Cycle cost of one active path, counted against the budget
  // ***************************************************************
  localparam logic [15:0] PATH_COST = 16'h0001;

  function automatic logic [15:0] count_paths(input src_paths_s p);
    logic [15:0] n;
    n = '0;
    n = n + 16'(p.async_en[0]) + 16'(p.async_en[1]);
    n = n + 16'(p.async_en[2]) + 16'(p.async_en[3]);
    for (int i = 0; i < 4; i++) begin
      n = n + 16'(p.i1_interp[i]) + 16'(p.i1_decim[i]);
    end
    for (int i = 0; i < 2; i++) begin
      n = n + 16'(p.i2_interp[i]) + 16'(p.i2_decim[i]);
    end
    return n * PATH_COST;
  endfunction

  function automatic logic [3:0] rate_field(input logic [15:0] d);
    return d[`SRC_RATE_MSB:`SRC_RATE_LSB];
  endfunction

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [3:0]  async_req;
  logic [15:0] i1_req;
  logic [15:0] i2_req;
  src_paths_s  active;
  src_chk_e    chk;
  logic        err;
  logic [3:0]  next_async_req;
  logic [15:0] next_i1_req;
  logic [15:0] next_i2_req;
  logic [3:0]  next_sys_rate;
  logic [3:0]  next_alt_rate;
  logic [3:0]  next_i1_high;
  logic [3:0]  next_i1_low;
  logic [3:0]  next_i2_high;
  logic [3:0]  next_i2_low;
  src_paths_s  next_active;
  src_paths_s  wanted;
  src_chk_e    next_chk;
  logic        next_err;
  logic [15:0] next_rdata;
  logic [3:0]  next_lock;

  always_comb begin
    next_async_req = async_req;
    next_i1_req    = i1_req;
    next_i2_req    = i2_req;
    next_sys_rate  = sys_rate_sel;
    next_alt_rate  = alt_rate_sel;
    next_i1_high   = i1_high_sel;
    next_i1_low    = i1_low_sel;
    next_i2_high   = i2_high_sel;
    next_i2_low    = i2_low_sel;
    if (req.wr) begin
      case (req.addr)
        `SRC_ADDR_ENABLE:   next_async_req = req.wdata[3:0]; // [R1] [R2]
        `SRC_ADDR_SYS_RATE: next_sys_rate  = rate_field(req.wdata); // [R4]
        `SRC_ADDR_ALT_RATE: next_alt_rate  = rate_field(req.wdata); // [R5]
        `SRC_ADDR_I1_HIGH:  next_i1_high   = rate_field(req.wdata); // [R14]
        `SRC_ADDR_I1_LOW:   next_i1_low    = rate_field(req.wdata); // [R14]
        `SRC_ADDR_I1_PATHS: next_i1_req    = req.wdata; // [R17] [R18]
        `SRC_ADDR_I2_HIGH:  next_i2_high   = rate_field(req.wdata); // [R14]
        `SRC_ADDR_I2_LOW:   next_i2_low    = rate_field(req.wdata); // [R14]
        `SRC_ADDR_I2_PATHS: next_i2_req    = req.wdata; // [R19]
        default:            next_async_req = async_req;
      endcase
    end
  end

  // ***************************************************************
  // Requested path set decoded from the control registers
  // ***************************************************************
  always_comb begin
    wanted.async_en  = async_req;
    wanted.i1_interp = i1_req[`SRC_I1_INT_MSB:`SRC_I1_INT_LSB]; // [R17] [R9]
    wanted.i1_decim  = i1_req[`SRC_I1_DEC_MSB:`SRC_I1_DEC_LSB]; // [R18] [R9]
    wanted.i1_notch  = i1_req[`SRC_NOTCH_BIT]; // [R20]
    wanted.i2_interp = i2_req[`SRC_I2_INT_MSB:`SRC_I2_INT_LSB]; // [R19]
    wanted.i2_decim  = i2_req[`SRC_I2_DEC_MSB:`SRC_I2_DEC_LSB]; // [R19]
    wanted.i2_notch  = i2_req[`SRC_NOTCH_BIT]; // [R20]
  end

  // ***************************************************************
  // Clock sufficiency gate: refused enables leave active paths alone
  // ***************************************************************
  always_comb begin
    src_paths_s trial;
    trial       = '0;
    next_active = active;
    next_chk    = chk;
    next_err    = err;
    case (chk)
      SRC_CHK_IDLE: begin
        if (wanted != active) begin
          next_chk = SRC_CHK_EVAL;
        end
      end
      SRC_CHK_EVAL: begin
        // Disables and notch changes always take effect
        trial           = active & wanted;
        trial.i1_notch  = wanted.i1_notch;
        trial.i2_notch  = wanted.i2_notch;
        if (count_paths(wanted) <= cycle_budget) begin
          next_active = wanted; // [R24]
          next_err    = 1'b0;
          next_chk    = SRC_CHK_IDLE;
        end else begin
          next_active = trial; // [R21]
          next_err    = 1'b1; // [R22]
          next_chk    = SRC_CHK_ERROR;
        end
      end
      SRC_CHK_ERROR: begin
        // Wait until software writes any register, then re-check
        next_active.i1_notch = wanted.i1_notch;
        next_active.i2_notch = wanted.i2_notch;
        if ((wanted & ~active) == '0) begin
          next_active = wanted;
          next_err    = 1'b0;
          next_chk    = SRC_CHK_IDLE;
        end else if (req.wr) begin
          next_chk = SRC_CHK_EVAL;
        end
      end
      default: next_chk = SRC_CHK_IDLE;
    endcase
  end

  // ***************************************************************
  // Read mux and lock event
  // ***************************************************************
  always_comb begin
    next_rdata = `SRC_ZERO16;
    next_lock  = async_lock_in & active.async_en; // [R8]
    if (req.rd) begin
      case (req.addr)
        `SRC_ADDR_ENABLE:   next_rdata = {12'h000, async_req};
        `SRC_ADDR_STATUS:   next_rdata = {12'h000, active.async_en}; // [R3]
        `SRC_ADDR_SYS_RATE: next_rdata = {1'b0, sys_rate_sel, 11'h000};
        `SRC_ADDR_ALT_RATE: next_rdata = {1'b0, alt_rate_sel, 11'h000};
        `SRC_ADDR_I1_HIGH:  next_rdata = {1'b0, i1_high_sel, 11'h000};
        `SRC_ADDR_I1_LOW:   next_rdata = {1'b0, i1_low_sel, 11'h000};
        `SRC_ADDR_I1_PATHS: next_rdata = {i1_req[15:12], 2'b00,
                                          i1_req[9:6], 5'h00, i1_req[0]};
        `SRC_ADDR_I2_HIGH:  next_rdata = {1'b0, i2_high_sel, 11'h000};
        `SRC_ADDR_I2_LOW:   next_rdata = {1'b0, i2_low_sel, 11'h000};
        `SRC_ADDR_I2_PATHS: next_rdata = {i2_req[15:14], 4'h0,
                                          i2_req[9:8], 7'h00, i2_req[0]};
        default:            next_rdata = `SRC_ZERO16;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      async_req      <= 4'h0;
      i1_req         <= `SRC_ZERO16;
      i2_req         <= `SRC_ZERO16;
      sys_rate_sel   <= `SRC_RATE_SYS_RST;
      alt_rate_sel   <= `SRC_RATE_ALT_RST;
      i1_high_sel    <= `SRC_RATE_SYS_RST;
      i1_low_sel     <= `SRC_RATE_SYS_RST;
      i2_high_sel    <= `SRC_RATE_SYS_RST;
      i2_low_sel     <= `SRC_RATE_SYS_RST;
      active         <= '0;
      chk            <= SRC_CHK_IDLE;
      err            <= 1'b0;
      rdata          <= `SRC_ZERO16;
      async_lock     <= 4'h0;
    end else begin
      async_req      <= next_async_req;
      i1_req         <= next_i1_req;
      i2_req         <= next_i2_req;
      sys_rate_sel   <= next_sys_rate;
      alt_rate_sel   <= next_alt_rate;
      i1_high_sel    <= next_i1_high;
      i1_low_sel     <= next_i1_low;
      i2_high_sel    <= next_i2_high;
      i2_low_sel     <= next_i2_low;
      active         <= next_active;
      chk            <= next_chk;
      err            <= next_err;
      rdata          <= next_rdata;
      async_lock     <= next_lock;
    end
  end

  assign paths          = active;
  assign underclock_err = err; // [R22]
endmodule // src_ctrl

// file: test/src_ctrl_monitor.sv
// Assertion checker for the converter control block
`timescale 1ns/10ps
module src_ctrl_monitor (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Watched ports
  input wire src_pkg::src_req_s   req,
  input wire logic [15:0]         rdata,
  input wire logic [15:0]         cycle_budget,
  input wire logic [3:0]          async_lock_in,
  input wire src_pkg::src_paths_s paths,
  input wire logic [3:0]          sys_rate_sel,
  input wire logic [3:0]          alt_rate_sel,
  input wire logic [3:0]          i1_high_sel,
  input wire logic [3:0]          async_lock,
  input wire logic                underclock_err
);
  import src_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] bits;
  assign bits = {paths.async_en, paths.i1_interp, paths.i1_decim,
                 paths.i2_interp, paths.i2_decim};
  sequence s_rd_status;
    req.rd && !req.wr && req.addr == 16'h0EE1;
  endsequence
  sequence s_iso1_wr;
    req.wr && req.addr == 16'h0EF2 ##1 !req.wr;
  endsequence
  property p_rst_vals;
    !$past(rst_n) |-> alt_rate_sel == 4'h8 && sys_rate_sel == 4'h0
      && bits == 16'h0000 && !underclock_err;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset");
  property p_rd_idle;
    !(req.rd && !req.wr) |=> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
  property p_status;
    s_rd_status |=> rdata == {12'h000, $past(paths.async_en)};
  endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_lock;
    1'b1 |=> async_lock == $past(async_lock_in & paths.async_en);
  endproperty
  a_lock: assert property (p_lock) else $error("bad lock");
  property p_sys_rate;
    req.wr && req.addr == 16'h0EE2 |=> sys_rate_sel == $past(req.wdata[14:11]);
  endproperty
  a_sys_rate: assert property (p_sys_rate) else $error("bad rate");
  property p_i1_high;
    req.wr && req.addr == 16'h0EF0 |=> i1_high_sel == $past(req.wdata[14:11]);
  endproperty
  a_i1_high: assert property (p_i1_high) else $error("bad high");
  property p_err_no_gain;
    $rose(underclock_err) |-> (bits & ~$past(bits)) == 16'h0000;
  endproperty
  a_err_no_gain: assert property (p_err_no_gain) else $error("gain");
  property p_budget;
    (bits & ~$past(bits)) != 16'h0000
      |-> $countones(bits) <= $past(cycle_budget);
  endproperty
  a_budget: assert property (p_budget) else $error("over budget");
  property p_notch;
    s_iso1_wr |-> ##2 paths.i1_notch == $past(req.wdata[0], 3);
  endproperty
  a_notch: assert property (p_notch) else $error("bad notch");
  property p_interp;
    s_iso1_wr |-> ##2 paths.i1_interp[3] == $past(req.wdata[15], 3)
      || underclock_err;
  endproperty
  a_interp: assert property (p_interp) else $error("bad interp");
endmodule // src_ctrl_monitor
bind src_ctrl src_ctrl_monitor i_src_ctrl_monitor (.clk, .rst_n, .req,
  .rdata, .cycle_budget, .async_lock_in, .paths, .sys_rate_sel,
  .alt_rate_sel, .i1_high_sel, .async_lock, .underclock_err);

// file: test/src_core_model.sv
// Core-side model: clock budget and delayed path lock
`timescale 1ns/10ps
module src_core_model (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Bench settings and active paths
  input  wire logic [15:0]         budget_set,
  input  wire logic                slow,
  input  wire src_pkg::src_paths_s paths,
  // Answers to the block
  output logic [15:0]              cycle_budget,
  output logic [3:0]               async_lock_in
);
  import src_pkg::*;
  logic [3:0] stage, next_stage, next_lock;
  assign cycle_budget = budget_set;
  always_comb begin
    next_stage = rst_n ? paths.async_en : 4'h0;
    next_lock  = slow ? stage & paths.async_en : next_stage;
  end
  always_ff @(posedge clk) begin
    stage         <= next_stage;
    async_lock_in <= next_lock;
  end
endmodule // src_core_model

// file: test/src_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module src_ctrl_tb;
  import src_pkg::*;
  logic clk, rst_n, slow, underclock_err, e;
  src_req_s req;
  src_paths_s paths;
  logic [15:0] rdata, cycle_budget, budget_set, got;
  logic [3:0] async_lock_in, act, r, c;
  logic [15:0] addrs [6] = '{16'h0EE2, 16'h0EE3, 16'h0EF0, 16'h0EF1,
                             16'h0EF3, 16'h0EF4};
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
  logic [3:0] rc [5] = '{4'h3, 4'hF, 4'h1, 4'hF, 4'h0};
  logic [15:0] bc [5] = '{16'h0002, 16'h0002, 16'h0002, 16'h0004, 16'h0000};
  int miscompares = 0, total_checks = 0;
  src_ctrl i_src_ctrl (.clk, .rst_n, .req, .rdata, .cycle_budget,
    .async_lock_in, .paths, .sys_rate_sel(), .alt_rate_sel(),
    .i1_high_sel(), .i1_low_sel(), .i2_high_sel(), .i2_low_sel(),
    .async_lock(), .underclock_err);
  src_core_model i_src_core_model (.clk, .rst_n, .budget_set, .slow,
    .paths, .cycle_budget, .async_lock_in);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(logic [15:0] g, logic [15:0] x);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req.wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(logic [15:0] a);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [3:0] accept(logic [3:0] a, logic [3:0] q,
                                        logic [15:0] b);
    return ($countones(q) <= b) ? q : (a & q);
  endfunction
  // Run takes about 430 cycles
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    req = '0; rst_n = 1'b0; slow = 1'b0; budget_set = 16'h000C;
    void'($urandom(70));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(16'h0EE3); check(got, 16'h4000);
    // Sources stay cleared, so no rate change waits
    // Nothing is routed in at a mismatched rate
    foreach (codes[j]) foreach (addrs[i]) begin
      c = codes[j];
      if ((i == 0 && c[3]) || (i == 1 && !c[3])) continue;
      wr(addrs[i], (16'($urandom) & 16'h87FF) | {1'b0, c, 11'h000});
      rd(addrs[i]); check(got, {1'b0, c, 11'h000});
    end
    wr(16'h0EE1, 16'hFFFF);
    rd(16'h0EE1); check(got, 16'h0000);
    rd(16'h0EE4); check(got, 16'h0000);
    wr(16'h0EF2, 16'hF3C1);
    check({paths.i1_interp, paths.i1_decim, 7'h00, paths.i1_notch},
          16'hFF01);
    wr(16'h0EF5, 16'hC301);
    check({11'h000, paths.i2_interp, paths.i2_decim, paths.i2_notch},
          16'h001F);
    wr(16'h0EF5, 16'h0000);
    wr(16'h0EF2, 16'h0000);
    budget_set <= 16'h0002;
    wr(16'h0EF2, 16'h8001);
    wr(16'h0EF2, 16'hF3C1);
    check({paths.i1_interp, paths.i1_decim, 7'h00, paths.i1_notch},
          16'h8001);
    check({15'h0000, underclock_err}, 16'h0001);
    wr(16'h0EF2, 16'h0000);
    act = 4'h0;
    for (int i = 0; i < 25; i++) begin
      @(posedge clk);
      budget_set <= i < 5 ? bc[i] : 16'($urandom_range(4));
      slow <= 1'($urandom);
      r = i < 5 ? rc[i] : 4'($urandom);
      wr(16'h0EE0, {12'h000, r});
      e = |(r & ~act) && $countones(r) > budget_set;
      act = accept(act, r, budget_set);
      rd(16'h0EE1); check(got, {12'h000, act});
      check({15'h0000, underclock_err}, {15'h0000, e});
    end
    // Reset in mid-run must return alternate rate, status and error to defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(16'h0EE3);
    check(got, 16'h4000);
    rd(16'h0EE1);
    check(got, 16'h0000);
    check({15'h0000, underclock_err}, 16'h0000);
    give_verdict();
  end
endmodule // src_ctrl_tb
